/* hw/audio_out_pkg.sv */
// constants, types and register map of the audio output processing block
package audio_out_pkg;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int          PAIRS        = 12;
  localparam int          EMB_PAIRS    = 8;
  localparam int          GROUPS       = 4;
  localparam int          SAMPLE_W     = 24;
  localparam int          TRUNC_BITS   = 4;
  localparam int          WIDE_W       = 41;

  // ------------------------------------------------------------
  // register map, byte addresses
  // ------------------------------------------------------------
  localparam logic [11:0] TONE_CTRL_OFS = 12'h000;
  localparam logic [11:0] EMB_CTRL_OFS  = 12'h004;
  localparam logic [11:0] STATUS_OFS    = 12'h008;
  localparam logic [11:0] PROC_BASE_OFS = 12'h040;
  localparam int          ADDR_LSB      = 2;
  localparam int          ADDR_W        = 12;

  // field positions
  localparam int          LEVEL_BIT     = 0;
  localparam int          EN_LSB        = 0;
  localparam int          ACP_LSB       = 4;
  localparam int          USE24_LSB     = 8;
  localparam int          BYPASS_BIT    = 12;
  localparam int          GAIN_LSB      = 0;
  localparam int          GAIN_W        = 16;
  localparam int          MODE_LSB      = 16;
  localparam int          MODE_W        = 3;
  localparam int          ST_BLANK_BIT  = 0;
  localparam int          ST_BUSY_BIT   = 1;
  localparam int          ST_SD_BIT     = 2;

  // reset values
  localparam logic [3:0]  EN_RESET      = 4'hF;
  localparam logic [3:0]  ACP_RESET     = 4'hF;
  localparam logic [3:0]  USE24_RESET   = 4'hF;

  // ------------------------------------------------------------
  // tone generator
  // ------------------------------------------------------------
  localparam int          SAMPLE_HZ     = 48000;
  localparam int          TONE_HZ       = 1000;
  localparam int          BLANK_MS      = 250;
  localparam int          REPEAT_S      = 3;
  localparam int          TONE_SAMPLES  = SAMPLE_HZ / TONE_HZ;
  localparam logic [SAMPLE_W-1:0] AMP_M18 = 24'h101D3F; // -18 dBFS of full scale
  localparam logic [SAMPLE_W-1:0] AMP_M20 = 24'h0CCCCD; // -20 dBFS of full scale
  localparam logic [17:0] OSC_COEF      = 18'h042F9;    // 2*sin(pi/48), Q1.17
  localparam int          COEF_FRAC     = 17;

  // ------------------------------------------------------------
  // gain engine: linear gain Q16.32, one 0.1 dB factor per step
  // ------------------------------------------------------------
  localparam int          LIN_W         = 48;
  localparam int          LIN_FRAC      = 32;
  localparam logic [LIN_W-1:0] LIN_UNITY = 48'h0001_0000_0000;
  localparam logic [17:0] STEP_UP       = 18'h205EE;    // 10^(+0.005), Q1.17
  localparam logic [17:0] STEP_DOWN     = 18'h1FA24;    // 10^(-0.005), Q1.17
  localparam int          GAIN_MAX      = 960;          // tenths of a dB

  typedef enum logic [MODE_W-1:0] {
    pass_through, swap_channels, left_duplicate, right_duplicate,
    invert_left, invert_right, mono_average, mid_side
  } mode_t;

  typedef enum logic {gain_load, gain_step} gain_state_t;

endpackage : audio_out_pkg

/* hw/audio_out_proc.sv */
// audio output processing: tone source, per-pair manipulation and gain, embedder controls
`timescale 1ns/10ps
module audio_out_proc #(
  parameter int REPEAT_SAMPLES = audio_out_pkg::SAMPLE_HZ * audio_out_pkg::REPEAT_S,
  parameter int BLANK_SAMPLES  = audio_out_pkg::SAMPLE_HZ * audio_out_pkg::BLANK_MS / 1000
) (
  input  wire logic                                   hclk,
  input  wire logic                                   hresetn,
  input  wire logic                                   hsel,
  input  wire logic [31:0]                            haddr,
  input  wire logic [1:0]                             htrans,
  input  wire logic                                   hwrite,
  input  wire logic [2:0]                             hsize,
  input  wire logic [31:0]                            hwdata,
  input  wire logic                                   hready,
  output logic      [31:0]                            hrdata,
  output logic                                        hreadyout,
  output logic                                        hresp,
  input  wire logic                                   sample_tick,
  input  wire logic                                   sd_mode,
  input  wire logic [audio_out_pkg::PAIRS-1:0][23:0]  in_left,
  input  wire logic [audio_out_pkg::PAIRS-1:0][23:0]  in_right,
  input  wire logic [audio_out_pkg::PAIRS-1:0]        in_nonaudio,
  output logic      [audio_out_pkg::PAIRS-1:0][23:0]  out_left,
  output logic      [audio_out_pkg::PAIRS-1:0][23:0]  out_right,
  output logic                                        out_valid,
  output logic      [23:0]                            tone_left,
  output logic      [23:0]                            tone_right,
  output logic      [audio_out_pkg::GROUPS-1:0]       emb_group_en,
  output logic      [audio_out_pkg::GROUPS-1:0]       emb_acp_en,
  output logic                                        emb_bypass
);

  // ------------------------------------------------------------
  // saturating helper
  // ------------------------------------------------------------
  // clip a wide signed value to the sample range instead of wrapping
  function automatic logic [23:0] sat24(input logic signed [audio_out_pkg::WIDE_W-1:0] v);
    logic signed [audio_out_pkg::WIDE_W-1:0] hi;
    logic signed [audio_out_pkg::WIDE_W-1:0] lo;
    hi = (audio_out_pkg::WIDE_W)'(signed'(24'sh7FFFFF));
    lo = (audio_out_pkg::WIDE_W)'(signed'(24'sh800000));
    if (v > hi) sat24 = 24'h7FFFFF;
    else if (v < lo) sat24 = 24'h800000;
    else sat24 = v[23:0];
  endfunction : sat24

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  logic                          level_m20;
  logic [3:0]                    grp_en;
  logic [3:0]                    grp_acp;
  logic [3:0]                    grp_use24;
  logic                          bypass;
  logic [audio_out_pkg::PAIRS-1:0][15:0] gain_set;
  logic [audio_out_pkg::PAIRS-1:0][2:0]  mode_set;
  logic                          wr_pend;
  logic                          rd_pend;
  logic [11:0]                   wr_addr;
  logic [11:0]                   rd_addr;
  logic                          addr_take;
  logic                          blanking;
  logic                          proc_busy;
  logic [31:0]                   next_rdata;

  assign addr_take = hsel && htrans[1] && hready;

  // address phase capture; reads get one wait state so a write just before is seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      wr_addr   <= 12'h000;
      rd_addr   <= 12'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= addr_take && hwrite;
      rd_pend   <= addr_take && !hwrite;
      hreadyout <= !(addr_take && !hwrite);
      hresp     <= 1'b0;
      if (addr_take) begin
        wr_addr <= haddr[audio_out_pkg::ADDR_W-1:0];
        rd_addr <= haddr[audio_out_pkg::ADDR_W-1:0];
      end
    end
  end

  // write data phase; unmapped addresses are ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_m20 <= 1'b0;
      grp_en    <= audio_out_pkg::EN_RESET;
      grp_acp   <= audio_out_pkg::ACP_RESET;
      grp_use24 <= audio_out_pkg::USE24_RESET;
      bypass    <= 1'b0;
      gain_set  <= '0;
      mode_set  <= '0;
    end else if (wr_pend) begin
      if (wr_addr == audio_out_pkg::TONE_CTRL_OFS) begin
        level_m20 <= hwdata[audio_out_pkg::LEVEL_BIT];
      end else if (wr_addr == audio_out_pkg::EMB_CTRL_OFS) begin
        grp_en    <= hwdata[audio_out_pkg::EN_LSB +: 4];
        grp_acp   <= hwdata[audio_out_pkg::ACP_LSB +: 4];
        grp_use24 <= hwdata[audio_out_pkg::USE24_LSB +: 4];
        bypass    <= hwdata[audio_out_pkg::BYPASS_BIT];
      end else begin
        for (int i = 0; i < audio_out_pkg::PAIRS; i++) begin
          if (wr_addr == audio_out_pkg::PROC_BASE_OFS + 12'(i << audio_out_pkg::ADDR_LSB)) begin
            gain_set[i] <= hwdata[audio_out_pkg::GAIN_LSB +: audio_out_pkg::GAIN_W];
            mode_set[i] <= hwdata[audio_out_pkg::MODE_LSB +: audio_out_pkg::MODE_W];
          end
        end
      end
    end
  end

  // read mux; unmapped reads return zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd_addr == audio_out_pkg::TONE_CTRL_OFS) begin
      next_rdata[audio_out_pkg::LEVEL_BIT] = level_m20;
    end else if (rd_addr == audio_out_pkg::EMB_CTRL_OFS) begin
      next_rdata[audio_out_pkg::EN_LSB +: 4]    = grp_en;
      next_rdata[audio_out_pkg::ACP_LSB +: 4]   = grp_acp;
      next_rdata[audio_out_pkg::USE24_LSB +: 4] = grp_use24;
      next_rdata[audio_out_pkg::BYPASS_BIT]     = bypass;
    end else if (rd_addr == audio_out_pkg::STATUS_OFS) begin
      next_rdata[audio_out_pkg::ST_BLANK_BIT] = blanking;
      next_rdata[audio_out_pkg::ST_BUSY_BIT]  = proc_busy;
      next_rdata[audio_out_pkg::ST_SD_BIT]    = sd_mode;
    end else begin
      for (int i = 0; i < audio_out_pkg::PAIRS; i++) begin
        if (rd_addr == audio_out_pkg::PROC_BASE_OFS + 12'(i << audio_out_pkg::ADDR_LSB)) begin
          next_rdata[audio_out_pkg::GAIN_LSB +: audio_out_pkg::GAIN_W] = gain_set[i];
          next_rdata[audio_out_pkg::MODE_LSB +: audio_out_pkg::MODE_W] = mode_set[i];
        end
      end
    end
  end

  // read data registered in the wait cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h0000_0000;
    else if (rd_pend) hrdata <= next_rdata;
  end

  // ------------------------------------------------------------
  // tone generator
  // ------------------------------------------------------------
  logic [31:0]          rep_cnt;
  logic [7:0]           osc_phase;
  logic signed [31:0]   osc_x;
  logic signed [31:0]   osc_y;
  logic signed [31:0]   next_x;
  logic signed [31:0]   next_y;
  logic signed [49:0]   prod_y;
  logic signed [49:0]   prod_x;

  assign blanking = rep_cnt < 32'(BLANK_SAMPLES);

  // coupled-form oscillator, exact 48-sample period; reloaded once per 48-sample period so drift cannot grow
  always_comb begin
    prod_y = osc_y * $signed({14'h0000, audio_out_pkg::OSC_COEF});
    next_x = osc_x - prod_y[audio_out_pkg::COEF_FRAC +: 32];
    prod_x = next_x * $signed({14'h0000, audio_out_pkg::OSC_COEF});
    next_y = osc_y + prod_x[audio_out_pkg::COEF_FRAC +: 32];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rep_cnt    <= 32'h0000_0000;
      osc_phase  <= 8'h00;
      osc_x      <= 32'sh0000_0000;
      osc_y      <= 32'sh0000_0000;
      tone_left  <= 24'h000000;
      tone_right <= 24'h000000;
    end else if (sample_tick) begin
      rep_cnt <= (rep_cnt == 32'(REPEAT_SAMPLES - 1)) ? 32'h0000_0000 : rep_cnt + 32'h0000_0001;
      if (osc_phase == 8'(audio_out_pkg::TONE_SAMPLES - 1)) begin
        osc_phase <= 8'h00;
        osc_x     <= 32'(signed'(level_m20 ? audio_out_pkg::AMP_M20 : audio_out_pkg::AMP_M18));
        osc_y     <= 32'sh0000_0000;
      end else begin
        osc_phase <= osc_phase + 8'h01;
        osc_x     <= next_x;
        osc_y     <= next_y;
      end
      tone_right <= osc_x[23:0];
      tone_left  <= blanking ? 24'h000000 : osc_x[23:0];
    end
  end

  blank_left_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sample_tick && blanking |=> tone_left == 24'h000000 && tone_right == $past(osc_x[23:0]))
    else $error("tone left channel not silent while blanking");

  // ------------------------------------------------------------
  // gain engine: walks the pairs, converts tenths of a dB to linear
  // ------------------------------------------------------------
  // serial stepping trades update latency (up to 12 x 962 cycles) for one multiplier
  audio_out_pkg::gain_state_t  gain_state;
  logic [3:0]                  g_idx;
  logic [9:0]                  g_cnt;
  logic                        g_down;
  logic [47:0]                 g_acc;
  logic [65:0]                 g_prod;
  logic signed [15:0]          g_set;
  logic signed [15:0]          g_clamp;
  logic [audio_out_pkg::PAIRS-1:0][47:0] lin_gain;
  localparam logic signed [15:0] GMAX = 16'(audio_out_pkg::GAIN_MAX);
  assign g_set   = gain_set[g_idx];
  assign g_clamp = (g_set > GMAX) ? GMAX : (g_set < -GMAX) ? -GMAX : g_set;
  assign g_prod  = g_acc * (g_down ? audio_out_pkg::STEP_DOWN : audio_out_pkg::STEP_UP);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gain_state <= audio_out_pkg::gain_load;
      g_idx      <= 4'h0;
      g_cnt      <= 10'h000;
      g_down     <= 1'b0;
      g_acc      <= audio_out_pkg::LIN_UNITY;
      lin_gain   <= {audio_out_pkg::PAIRS{audio_out_pkg::LIN_UNITY}};
    end else begin
      case (gain_state)
        audio_out_pkg::gain_load: begin
          g_acc      <= audio_out_pkg::LIN_UNITY;
          g_down     <= g_clamp[15];
          g_cnt      <= g_clamp[15] ? 10'(-g_clamp) : 10'(g_clamp);
          gain_state <= audio_out_pkg::gain_step;
        end
        audio_out_pkg::gain_step: begin
          if (g_cnt == 10'h000) begin
            lin_gain[g_idx] <= g_acc;
            g_idx           <= (g_idx == 4'(audio_out_pkg::PAIRS - 1)) ? 4'h0 : g_idx + 4'h1;
            gain_state      <= audio_out_pkg::gain_load;
          end else begin
            g_acc <= g_prod[audio_out_pkg::COEF_FRAC +: audio_out_pkg::LIN_W];
            g_cnt <= g_cnt - 10'h001;
          end
        end
        default: gain_state <= audio_out_pkg::gain_load;
      endcase
    end
  end

  // ------------------------------------------------------------
  // per-pair processing, one pair per cycle after each sample tick
  // ------------------------------------------------------------
  logic [audio_out_pkg::PAIRS-1:0][23:0] lat_l;
  logic [audio_out_pkg::PAIRS-1:0][23:0] lat_r;
  logic [audio_out_pkg::PAIRS-1:0]       lat_na;
  logic [3:0]                            p_idx;
  logic signed [40:0]                    wl;
  logic signed [40:0]                    wr;
  logic [23:0]                           man_l;
  logic [23:0]                           man_r;
  logic [23:0]                           next_l;
  logic [23:0]                           next_r;
  logic signed [72:0]                    gp_l;
  logic signed [72:0]                    gp_r;
  logic                                  trunc;
  audio_out_pkg::mode_t                  p_mode;

  assign wl     = 41'(signed'(lat_l[p_idx]));
  assign wr     = 41'(signed'(lat_r[p_idx]));
  assign p_mode = audio_out_pkg::mode_t'(mode_set[p_idx]);

  // left/right manipulation; summing modes are halved so they cannot clip
  always_comb begin
    man_l = lat_l[p_idx];
    man_r = lat_r[p_idx];
    case (p_mode)
      audio_out_pkg::pass_through:    begin man_l = lat_l[p_idx]; man_r = lat_r[p_idx]; end
      audio_out_pkg::swap_channels:   begin man_l = lat_r[p_idx]; man_r = lat_l[p_idx]; end
      audio_out_pkg::left_duplicate:  begin man_l = lat_l[p_idx]; man_r = lat_l[p_idx]; end
      audio_out_pkg::right_duplicate: begin man_l = lat_r[p_idx]; man_r = lat_r[p_idx]; end
      audio_out_pkg::invert_left:     man_l = sat24(-wl);
      audio_out_pkg::invert_right:    man_r = sat24(-wr);
      audio_out_pkg::mono_average: begin
        man_l = sat24((wl + wr) >>> 1);
        man_r = sat24((wl + wr) >>> 1);
      end
      audio_out_pkg::mid_side: begin
        man_l = sat24((wl + wr) >>> 1);
        man_r = sat24((wl - wr) >>> 1);
      end
      default: begin man_l = lat_l[p_idx]; man_r = lat_r[p_idx]; end
    endcase
  end

  // gain, then SD 20-bit reduction on embedded pairs; non-audio skips both
  always_comb begin
    gp_l   = $signed(man_l) * $signed({1'b0, lin_gain[p_idx]});
    gp_r   = $signed(man_r) * $signed({1'b0, lin_gain[p_idx]});
    next_l = sat24(gp_l[audio_out_pkg::LIN_FRAC +: audio_out_pkg::WIDE_W]);
    next_r = sat24(gp_r[audio_out_pkg::LIN_FRAC +: audio_out_pkg::WIDE_W]);
    trunc  = sd_mode && (p_idx < 4'(audio_out_pkg::EMB_PAIRS)) && !grp_use24[p_idx[2:1]];
    if (trunc) begin
      next_l[audio_out_pkg::TRUNC_BITS-1:0] = '0;
      next_r[audio_out_pkg::TRUNC_BITS-1:0] = '0;
    end
    if (lat_na[p_idx]) begin
      next_l = lat_l[p_idx];
      next_r = lat_r[p_idx];
    end
  end

  // a tick that lands while busy is dropped; ticks are thousands of cycles apart
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      proc_busy <= 1'b0;
      p_idx     <= 4'h0;
      lat_l     <= '0;
      lat_r     <= '0;
      lat_na    <= '0;
      out_left  <= '0;
      out_right <= '0;
      out_valid <= 1'b0;
    end else begin
      out_valid <= 1'b0;
      if (!proc_busy) begin
        if (sample_tick) begin
          lat_l     <= in_left;
          lat_r     <= in_right;
          lat_na    <= in_nonaudio;
          p_idx     <= 4'h0;
          proc_busy <= 1'b1;
        end
      end else begin
        out_left[p_idx]  <= next_l;
        out_right[p_idx] <= next_r;
        if (p_idx == 4'(audio_out_pkg::PAIRS - 1)) begin
          proc_busy <= 1'b0;
          out_valid <= 1'b1;
        end else begin
          p_idx <= p_idx + 4'h1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // embedder controls
  // ------------------------------------------------------------
  // control packet follows its own switch only, never the 20-bit choice; HD keeps it on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      emb_group_en <= audio_out_pkg::EN_RESET;
      emb_acp_en   <= audio_out_pkg::ACP_RESET;
      emb_bypass   <= 1'b0;
    end else begin
      emb_group_en <= grp_en;
      emb_acp_en   <= sd_mode ? grp_acp : 4'hF;
      emb_bypass   <= bypass;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  proc_latency_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sample_tick && !proc_busy |=> proc_busy [*8] ##1 proc_busy ##4 out_valid)
    else $error("processing did not finish in twelve cycles");

  pass_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
    proc_busy && p_mode == audio_out_pkg::pass_through |-> man_l == lat_l[p_idx] && man_r == lat_r[p_idx])
    else $error("pass-through altered the pair");

  swap_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
    proc_busy && p_mode == audio_out_pkg::swap_channels |-> man_l == lat_r[p_idx] && man_r == lat_l[p_idx])
    else $error("swap did not exchange channels");

  left_dup_a: assert property (@(posedge hclk) disable iff (!hresetn)
    proc_busy && p_mode == audio_out_pkg::left_duplicate |-> man_r == lat_l[p_idx] && man_l == man_r)
    else $error("left duplicate mismatch");

  invert_sat_a: assert property (@(posedge hclk) disable iff (!hresetn)
    proc_busy && p_mode == audio_out_pkg::invert_left |->
      man_l == ((lat_l[p_idx] == 24'h800000) ? 24'h7FFFFF : 24'(-wl)) && man_r == lat_r[p_idx])
    else $error("left inversion wrong or wrapped");

  mono_half_a: assert property (@(posedge hclk) disable iff (!hresetn)
    proc_busy && p_mode == audio_out_pkg::mono_average |-> man_l == man_r && man_l == 24'((wl + wr) >>> 1))
    else $error("mono average not halved sum");

  nonaudio_pass_a: assert property (@(posedge hclk) disable iff (!hresetn)
    proc_busy && lat_na[p_idx] |=> out_left[$past(p_idx)] == $past(lat_l[p_idx]))
    else $error("non-audio word changed");

  trunc_nibble_a: assert property (@(posedge hclk) disable iff (!hresetn)
    proc_busy && trunc && !lat_na[p_idx] |-> next_l[3:0] == 4'h0 && next_r[3:0] == 4'h0)
    else $error("20-bit reduction left low bits");

endmodule : audio_out_proc

/* dv/matrix_model.sv */
// matrix side model: offers one stereo sample to every pair on request
`timescale 1ns/10ps
module matrix_model (
  input  wire logic                hclk,
  input  wire logic                send,
  input  wire logic [23:0]         l_val,
  input  wire logic [23:0]         r_val,
  output logic                     sample_tick = 1'h0,
  output logic      [11:0][23:0]   in_left     = '0,
  output logic      [11:0][23:0]   in_right    = '0
);
  // tick lasts one cycle; samples are held after it, like the real matrix
  always @(posedge hclk) begin
    sample_tick <= send;
    if (send) begin
      in_left  <= {12{l_val}};
      in_right <= {12{r_val}};
    end
  end
endmodule : matrix_model

/* dv/testbench.sv */
// self-checking bench for the audio output processing block
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  err_total++; $display("wrong value %s expected %h seen %h", n, e, g); end end
module testbench;
  logic              hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, sd_mode = 1'h0, send = 1'h0;
  logic [1:0]        htrans = 2'h0;
  logic [2:0]        hsize = 3'h2;
  logic [31:0]       haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [23:0]       l_val = 24'h0, r_val = 24'h0, tone_left, tone_right;
  logic [11:0]       in_nonaudio = 12'h002;
  logic [11:0][23:0] in_left, in_right, out_left, out_right;
  logic [3:0]        emb_group_en, emb_acp_en;
  logic              hreadyout, sample_tick, out_valid, emb_bypass, hresp;
  int                err_total = 0, cmp_count = 0, tick_n = 0;
  audio_out_proc #(.REPEAT_SAMPLES(30), .BLANK_SAMPLES(3)) audio_out_proc_inst (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .sample_tick, .sd_mode, .in_left, .in_right, .in_nonaudio, .out_left, .out_right, .out_valid,
    .tone_left, .tone_right, .emb_group_en, .emb_acp_en, .emb_bypass);
  matrix_model matrix_model_inst (.hclk, .send, .l_val, .r_val, .sample_tick, .in_left, .in_right);
  always #2 hclk = ~hclk;
  // single transfer; holds each phase until hready is seen high
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1; htrans <= 2'h2; hwrite <= wr; haddr <= {20'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    q = hrdata;
    `CHK("okay response", 1'h0, hresp)
    #1;
  endtask : ahb
  // one sample through all pairs; bounded wait on the completion pulse
  task automatic sample(input logic [23:0] l, input logic [23:0] r);
    int n = 0;
    @(posedge hclk);
    send <= 1'h1; l_val <= l; r_val <= r;
    tick_n++;
    @(posedge hclk) send <= 1'h0;
    do begin @(posedge hclk); n++; end while (out_valid !== 1'h1 && n < 40);
    `CHK("out_valid", 1'h1, out_valid)
    #1;
  endtask : sample
  function automatic logic [47:0] pair_exp(input int m, input logic signed [23:0] l, r);
    logic signed [24:0] s, d;
    s = l + r;
    d = l - r;
    case (m)
      0: return {l, r};
      1: return {r, l};
      2: return {l, l};
      3: return {r, r};
      4: return {-l, r};
      5: return {l, -r};
      6: return {s[24:1], s[24:1]};
      default: return {s[24:1], d[24:1]};
    endcase
  endfunction : pair_exp
  task automatic regs_check();
    ahb(1'h0, 12'h004, 32'h0);
    `CHK("emb_ctrl reset", 32'h0000_0FFF, q)
    ahb(1'h0, 12'h020, 32'h0);
    `CHK("unmapped read", 32'h0, q)
    ahb(1'h0, 12'h008, 32'h0);
    `CHK("status after reset", 32'h0000_0001, q)
    ahb(1'h1, 12'h000, 32'h1);
    ahb(1'h0, 12'h000, 32'h0);
    `CHK("tone level", 1'h1, q[0])
  endtask : regs_check
  // peak after the first sine period, blanking at the cycle start, then the other level
  task automatic tone_check();
    while (tick_n < 49) sample(24'h0, 24'h0);
    `CHK("tone peak left", audio_out_pkg::AMP_M20, tone_left)
    `CHK("tone peak right", audio_out_pkg::AMP_M20, tone_right)
    while (tick_n < 62) sample(24'h0, 24'h0);
    `CHK("blanked left", 24'h0, tone_left)
    `CHK("running right", 1'h1, tone_right != 24'h0)
    ahb(1'h1, 12'h000, 32'h0);
    while (tick_n < 97) sample(24'h0, 24'h0);
    `CHK("tone -18 left", audio_out_pkg::AMP_M18, tone_left)
    `CHK("tone -18 right", audio_out_pkg::AMP_M18, tone_right)
  endtask : tone_check
  // +96 dB clips both ways on pair 8; -96 dB leaves only a few codes on pair 9
  task automatic gain_check();
    ahb(1'h1, 12'h060, 32'h0000_03C0);
    ahb(1'h1, 12'h064, 32'h0000_FC40);
    repeat (2100) @(posedge hclk);
    sample(24'h300000, 24'hD00000);
    `CHK("clip high", 24'h7FFFFF, out_left[8])
    `CHK("clip low", 24'h800000, out_right[8])
    `CHK("gain -96 dB", 1'h1, out_left[9] > 24'h20 && out_left[9] < 24'h40)
  endtask : gain_check
  // every mode on pair 0; pair 1 is data in swap mode and must stay untouched
  task automatic modes_check();
    ahb(1'h1, 12'h044, 32'h0001_0000);
    for (int m = 0; m < 8; m++) begin
      ahb(1'h1, 12'h040, 32'(m) << 16);
      sample(24'h300000, 24'h100000);
      `CHK("left", pair_exp(m, 24'h300000, 24'h100000) >> 24, 48'(out_left[0]))
      `CHK("right", pair_exp(m, 24'h300000, 24'h100000) & 48'hFFFFFF, 48'(out_right[0]))
      `CHK("data word", 24'h300000, out_left[1])
    end
  endtask : modes_check
  // group enables, bypass, control packet in HD then SD, 20-bit reduction
  task automatic embed_check();
    ahb(1'h1, 12'h004, 32'h0000_10A5);
    ahb(1'h1, 12'h040, 32'h0);
    sample(24'h12345F, 24'h0ABCDE);
    `CHK("group enable", 4'h5, emb_group_en)
    `CHK("bypass", 1'h1, emb_bypass)
    `CHK("hd packet", 4'hF, emb_acp_en)
    @(posedge hclk) sd_mode <= 1'h1;
    sample(24'h12345F, 24'h0ABCDE);
    `CHK("sd packet", 4'hA, emb_acp_en)
    `CHK("cut left", 24'h123450, out_left[0])
    `CHK("cut right", 24'h0ABCD0, out_right[0])
  endtask : embed_check
  task automatic print_verdict();
    if (err_total == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  // watchdog well beyond the few thousand cycles the run needs
  initial begin
    #200000 err_total++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    regs_check();
    tone_check();
    modes_check();
    embed_check();
    gain_check();
    print_verdict();
  end
endmodule : testbench
